// *** logic/adc_regs.svh ***
// Offsets, field positions, reset values and timing counts of the converter control block
`ifndef ADC_REGS_SVH
`define ADC_REGS_SVH

// ************************************************************
// Register bus
// ************************************************************
`define WB_ADR_W        4
`define ADDR_SAMPLE     4'h0
`define ADDR_MEAS       4'h4
`define ADDR_STATUS     4'h8
`define ADDR_RESULT     4'hc
`define MEAS_LIN_LSB    16
`define ST_WLEN_LSB     16

// ************************************************************
// Serial link and instruction
// ************************************************************
`define INSTR_BITS      5'h08
`define BITCNT_MAX      5'h1f
`define OP_CONVERT      3'h0
`define OP_CAL          3'h1
`define OP_ZERO         3'h2
`define OP_PWR_UP       3'h3
`define OP_PWR_DOWN     3'h4
`define OP_SIGN         3'h5
`define OP_ACQ          3'h6
`define OP_MODE         3'h7
`define WLEN_NO_SIGN    5'h0c
`define WLEN_SIGN       5'h0d
`define WLEN_LONG_ADD   5'h04

// ************************************************************
// Timing in conversion clock periods
// ************************************************************
`define MCLK_HZ         25000000
`define CONVERSION_CLOCK_HZ         5000000
`define CONVERSION_CLOCK_DIV        (`MCLK_HZ / `CONVERSION_CLOCK_HZ)
`define ACQ_CODE_6      2'h0
`define ACQ_CODE_10     2'h1
`define ACQ_CODE_18     2'h2
`define ACQ_CODE_34     2'h3
`define ACQ_CONVERSION_CLOCK_6      8'h06
`define ACQ_CONVERSION_CLOCK_10     8'h0a
`define ACQ_CONVERSION_CLOCK_18     8'h12
`define ACQ_CONVERSION_CLOCK_34     8'h22
`define CONV_CONVERSION_CLOCK       8'h0d

// ************************************************************
// Power-up configuration
// ************************************************************
`define DEF_ACQ         `ACQ_CODE_10
`define DEF_SIGN        1'b1
`define DEF_POWERED     1'b1
`define DEF_LSB_FIRST   1'b0
`define DEF_TEST_MODE   1'b0

`endif

// *** logic/adc_pkg.sv ***
// Types of the converter control block
package adc_pkg;

  typedef enum logic [2:0] {IDLE, ACQ, CONV, RD_OFF, RD_SEG, TAKE, FIN, CAL} phase_e;

  typedef struct packed {
    logic [1:0] acq;
    logic       sign_en;
    logic       lsb_first;
    logic       long_fmt;
    logic [2:0] mux;
    logic       powered;
    logic       test_mode;
  } cfg_s;

  typedef struct packed {
    logic        sclk_m, sclk_s, sclk_d;
    logic        cs_m, cs_s, cs_d;
    logic        din_m, din_s;
    logic [16:0] sh;
    logic [4:0]  bitcnt;
    logic [7:0]  instr;
    logic        drive_n;
    cfg_s        cfg;
    phase_e      phase;
    logic        zero_only;
    logic [7:0]  cdiv;
    logic [7:0]  cnt;
    logic [3:0]  maddr;
    logic        mem_we;
    logic [3:0]  mem_waddr;
    logic [12:0] mem_wdata;
    logic        cal_done;
    logic        zero_done;
    logic [12:0] conv_in;
    logic [12:0] off;
    logic [12:0] result;
    logic [12:0] sample;
    logic [12:0] meas_off;
    logic [12:0] meas_lin;
    logic        busy;
    logic        ack;
    logic [31:0] rdat;
  } state_s;

endpackage

// *** logic/cal_store.sv ***
// Correction value memory with registered read data
`timescale 1ns/100ps
`default_nettype none

module cal_store #(
  parameter int DEPTH = 9,
  parameter int AW    = 4,
  parameter int DW    = 13
) (
  // Clock
  input  wire logic          i_mclk,
  // Write port
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [DW-1:0] i_wdata,
  // Read port
  input  wire logic [AW-1:0] i_raddr,
  output logic      [DW-1:0] o_rdata
);

  logic [DW-1:0] mem [DEPTH];

  if (DEPTH > (1 << AW))
  begin : g_chk
    $error("cal_store depth exceeds address range");
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_we)
    begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end

endmodule // cal_store

`default_nettype wire

// *** logic/adc_mode_setup_and_readout.sv ***
// Mode setup, calibration and serial readout of the converter control block
//
// Decided for this implementation: the Wishbone interface to the registers and the register addresses.
`include "adc_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module adc_mode_setup_and_readout #(
  parameter int CONVERSION_CLOCK_DIV = `CONVERSION_CLOCK_DIV,
  parameter int SEG_BITS = 3
) (
  // Clock and reset
  input  wire logic                 i_mclk,
  input  wire logic                 i_rst_n,
  // Wishbone slave
  input  wire logic                 i_wb_cyc,
  input  wire logic                 i_wb_stb,
  input  wire logic                 i_wb_we,
  input  wire logic [`WB_ADR_W-1:0] i_wb_adr,
  input  wire logic [3:0]           i_wb_sel,
  input  wire logic [31:0]          i_wb_dat,
  output logic      [31:0]          o_wb_dat,
  output logic                      o_wb_ack,
  // Serial link
  input  wire logic                 i_sclk,
  input  wire logic                 i_cs_n,
  input  wire logic                 i_serial_in,
  output logic                      o_serial_out,
  output logic                      o_serial_out_en_n,
  // Status
  output logic                      o_busy
);
  import adc_pkg::*;

  localparam int DEPTH = 1 + (1 << SEG_BITS);

  if (CONVERSION_CLOCK_DIV < 2 || CONVERSION_CLOCK_DIV > 255 || SEG_BITS < 1 || SEG_BITS > 3)
  begin : g_chk
    $error("adc_mode_setup_and_readout parameter out of range");
  end

  state_s      st;
  state_s      next_st;
  logic [12:0] mem_rdata;
  logic [12:0] res_rev;

  // ************************************************************
  // Correction store
  // ************************************************************
  cal_store #(
    .DEPTH (DEPTH),
    .AW    (4),
    .DW    (13)
  ) u_store (
    .i_mclk  (i_mclk),
    .i_we    (st.mem_we),
    .i_waddr (st.mem_waddr),
    .i_wdata (st.mem_wdata),
    .i_raddr (st.maddr),
    .o_rdata (mem_rdata)
  );

  // Bit-reversed result for LSB-first output
  for (genvar i = 0; i < 13; i++)
  begin : g_rev
    assign res_rev[i] = st.result[12-i];
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] sel);
    logic [31:0] v;
    v = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        v[8*b +: 8] = dat[8*b +: 8];
      end
    end
    return v;
  endfunction

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    logic        rise;
    logic        fall;
    logic        cs_start;
    logic        cs_end;
    logic        tick;
    logic [7:0]  acq_len;
    logic [4:0]  wlen;
    logic [16:0] word;
    logic [31:0] tmp;
    rise     = st.sclk_s & ~st.sclk_d;
    fall     = ~st.sclk_s & st.sclk_d;
    cs_start = ~st.cs_s & st.cs_d;
    cs_end   = st.cs_s & ~st.cs_d;
    tick     = (st.cdiv == 8'(CONVERSION_CLOCK_DIV - 1));
    tmp      = '0;
    next_st  = st;
    next_st.mem_we = 1'b0;

    next_st.sclk_m = i_sclk;
    next_st.sclk_s = st.sclk_m;
    next_st.sclk_d = st.sclk_s;
    next_st.cs_m   = i_cs_n;
    next_st.cs_s   = st.cs_m;
    next_st.cs_d   = st.cs_s;
    next_st.din_m  = i_serial_in;
    next_st.din_s  = st.din_m;
    next_st.cdiv   = tick ? 8'h00 : st.cdiv + 8'h01;

    unique case (st.cfg.acq)
      `ACQ_CODE_6:  acq_len = `ACQ_CONVERSION_CLOCK_6;
      `ACQ_CODE_10: acq_len = `ACQ_CONVERSION_CLOCK_10;
      `ACQ_CODE_18: acq_len = `ACQ_CONVERSION_CLOCK_18;
      `ACQ_CODE_34: acq_len = `ACQ_CONVERSION_CLOCK_34;
    endcase

    // Word length and layout follow sign and format settings
    wlen = (st.cfg.sign_en ? `WLEN_SIGN : `WLEN_NO_SIGN) + (st.cfg.long_fmt ? `WLEN_LONG_ADD : 5'h00);
    if (st.cfg.sign_en)
    begin
      word = {(st.cfg.lsb_first ? res_rev : st.result), 4'h0};
    end
    else
    begin
      word = {(st.cfg.lsb_first ? res_rev[12:1] : st.result[11:0]), 5'h00};
    end

    // ************************************************************
    // Serial link
    // ************************************************************
    if (cs_start)
    begin
      next_st.sh      = word;
      next_st.bitcnt  = 5'h00;
      next_st.drive_n = 1'b0;
    end
    else if (!st.cs_s && rise)
    begin
      if (st.bitcnt < `INSTR_BITS)
      begin
        next_st.instr = {st.instr[6:0], st.din_s};
      end
      if (st.bitcnt != `BITCNT_MAX)
      begin
        next_st.bitcnt = st.bitcnt + 5'h01;
      end
    end
    else if (!st.cs_s && fall)
    begin
      next_st.sh = {st.sh[15:0], 1'b0};
    end

    if (cs_end)
    begin
      next_st.drive_n = 1'b1;
      if (st.bitcnt >= `INSTR_BITS && st.phase == IDLE)
      begin
        unique case (st.instr[7:5])
          `OP_CONVERT:
          begin
            next_st.cfg.mux       = st.instr[4:2];
            next_st.cfg.lsb_first = st.instr[1];
            next_st.cfg.long_fmt  = st.instr[0];
            if (st.cfg.powered)
            begin
              next_st.phase = ACQ;
              next_st.cnt   = 8'h00;
            end
          end
          `OP_CAL:
          begin
            if (st.cfg.powered)
            begin
              next_st.phase     = CAL;
              next_st.zero_only = 1'b0;
              next_st.cnt       = 8'h00;
            end
          end
          `OP_ZERO:
          begin
            if (st.cfg.powered)
            begin
              next_st.phase     = CAL;
              next_st.zero_only = 1'b1;
              next_st.cnt       = 8'h00;
            end
          end
          `OP_PWR_UP:   next_st.cfg.powered   = 1'b1;
          `OP_PWR_DOWN: next_st.cfg.powered   = 1'b0;
          `OP_SIGN:     next_st.cfg.sign_en   = st.instr[0];
          `OP_ACQ:      next_st.cfg.acq       = st.instr[1:0];
          `OP_MODE:     next_st.cfg.test_mode = st.instr[0];
        endcase
      end
    end

    // ************************************************************
    // Conversion and calibration sequencing
    // ************************************************************
    unique case (st.phase)
      IDLE: ;
      ACQ:
      begin
        if (tick)
        begin
          next_st.cnt = st.cnt + 8'h01;
          if (st.cnt == acq_len - 8'h01)
          begin
            next_st.conv_in = st.sample;
            next_st.phase   = CONV;
            next_st.cnt     = 8'h00;
          end
        end
      end
      CONV:
      begin
        if (tick)
        begin
          next_st.cnt = st.cnt + 8'h01;
          if (st.cnt == `CONV_CONVERSION_CLOCK - 8'h01)
          begin
            next_st.phase = RD_OFF;
          end
        end
      end
      RD_OFF:
      begin
        next_st.maddr = 4'h0;
        next_st.phase = RD_SEG;
      end
      RD_SEG:
      begin
        next_st.maddr = 4'h1 + 4'(st.conv_in[11 -: SEG_BITS]);
        next_st.phase = TAKE;
      end
      TAKE:
      begin
        next_st.off   = st.zero_done ? mem_rdata : 13'h0000;
        next_st.phase = FIN;
      end
      FIN:
      begin
        next_st.result = st.conv_in - st.off - (st.cal_done ? mem_rdata : 13'h0000);
        next_st.phase  = IDLE;
      end
      CAL:
      begin
        if (tick)
        begin
          // Entry 0 holds offset, the rest linearity per segment
          next_st.mem_we    = 1'b1;
          next_st.mem_waddr = st.cnt[3:0];
          next_st.mem_wdata = (st.cnt == 8'h00) ? st.meas_off : st.meas_lin;
          next_st.cnt       = st.cnt + 8'h01;
          if (st.zero_only || st.cnt == 8'(DEPTH - 1))
          begin
            next_st.phase     = IDLE;
            next_st.zero_done = 1'b1;
            next_st.cal_done  = st.cal_done | ~st.zero_only;
          end
        end
      end
    endcase
    next_st.busy = (next_st.phase != IDLE);

    // ************************************************************
    // Wishbone slave
    // ************************************************************
    next_st.ack  = i_wb_cyc & i_wb_stb & ~st.ack;
    next_st.rdat = '0;
    if (i_wb_cyc && i_wb_stb && !st.ack)
    begin
      unique case (i_wb_adr)
        `ADDR_SAMPLE:
        begin
          tmp = merge({19'h00000, st.sample}, i_wb_dat, i_wb_sel);
          next_st.rdat = {19'h00000, st.sample};
          if (i_wb_we)
          begin
            next_st.sample = tmp[12:0];
          end
        end
        `ADDR_MEAS:
        begin
          tmp = merge({3'h0, st.meas_lin, 3'h0, st.meas_off}, i_wb_dat, i_wb_sel);
          next_st.rdat = {3'h0, st.meas_lin, 3'h0, st.meas_off};
          if (i_wb_we)
          begin
            next_st.meas_off = tmp[12:0];
            next_st.meas_lin = tmp[`MEAS_LIN_LSB +: 13];
          end
        end
        `ADDR_STATUS:
        begin
          next_st.rdat = {11'h000, wlen, 3'h0, st.cfg, st.zero_done, st.cal_done, st.busy};
        end
        `ADDR_RESULT:
        begin
          next_st.rdat = {19'h00000, st.result};
        end
        default: next_st.rdat = '0;
      endcase
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st                   <= '0;
      st.cs_m              <= 1'b1;
      st.cs_s              <= 1'b1;
      st.cs_d              <= 1'b1;
      st.drive_n           <= 1'b1;
      st.phase             <= IDLE;
      st.cfg.acq           <= `DEF_ACQ;
      st.cfg.sign_en       <= `DEF_SIGN;
      st.cfg.powered       <= `DEF_POWERED;
      st.cfg.lsb_first     <= `DEF_LSB_FIRST;
      st.cfg.test_mode     <= `DEF_TEST_MODE;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign o_serial_out      = st.sh[16];
  assign o_serial_out_en_n = st.drive_n;
  assign o_busy            = st.busy;
  assign o_wb_ack          = st.ack;
  assign o_wb_dat          = st.rdat;

endmodule // adc_mode_setup_and_readout

`default_nettype wire

// *** tb/adc_mode_setup_and_readout_assertions.sv ***
// Concurrent checks on the ports of the converter control block
`timescale 1ns/100ps
`default_nettype none

module adc_mode_setup_and_readout_checker #(
  parameter int CONVERSION_CLOCK_DIV = 5
) (
  input wire logic        i_mclk,
  input wire logic        i_rst_n,
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_wb_ack,
  input wire logic        i_sclk,
  input wire logic        i_cs_n,
  input wire logic        o_serial_out,
  input wire logic        o_serial_out_en_n,
  input wire logic        o_busy
);
  // ************************************************************
  // Busy length counter
  // ************************************************************
  localparam int LIM = 60 * CONVERSION_CLOCK_DIV + 8;
  logic [15:0] bcnt;
  always_ff @(posedge i_mclk or negedge i_rst_n)
    if (!i_rst_n)
      bcnt <= 16'h0000;
    else
      bcnt <= o_busy ? bcnt + 16'h0001 : 16'h0000;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack longer than one cycle");
  a_ack_latency: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("ack late");
  a_ack_cause: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb)) else $error("ack without request");
  a_dat_idle: assert property (!o_wb_ack |-> o_wb_dat == 32'h00000000) else $error("data outside ack");
  a_drive_on_select: assert property ($fell(i_cs_n) |-> ##[1:4] !o_serial_out_en_n) else $error("no drive");
  a_release_idle: assert property (i_cs_n [*4] |-> o_serial_out_en_n) else $error("drive while idle");
  a_busy_start: assert property ($rose(o_busy) |-> i_cs_n) else $error("busy inside transfer");
  a_busy_bound: assert property (bcnt < LIM) else $error("busy too long");
  a_out_hold: assert property (i_sclk [*3] |-> $stable(o_serial_out)) else $error("output moved");

  c_bus: cover property (o_wb_ack);
  c_busy: cover property ($rose(o_busy));
  c_frame: cover property ($fell(i_cs_n));
endmodule // adc_mode_setup_and_readout_checker

bind adc_mode_setup_and_readout adc_mode_setup_and_readout_checker #(.CONVERSION_CLOCK_DIV(CONVERSION_CLOCK_DIV)) u_chk (
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_sclk(i_sclk), .i_cs_n(i_cs_n),
  .o_serial_out(o_serial_out), .o_serial_out_en_n(o_serial_out_en_n), .o_busy(o_busy)
);
`default_nettype wire

// *** tb/host_model.sv ***
// Host model driving the serial instruction link
`timescale 1ns/100ps
`default_nettype none

module host_model (
  // Link
  input  wire logic i_serial_out,
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_serial_in
);
  // ************************************************************
  // Transfer
  // ************************************************************
  initial
  begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_serial_in = 1'b0;
  end

  // Phase offset keeps every link edge 7 ns after a system clock edge
  task automatic xfer(input logic [7:0] ins, input int n, output logic [16:0] w);
    w = 17'h00000;
    #7 o_cs_n = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      #140 o_serial_in = (i < 8) ? ins[7 - i] : ~o_serial_in;
      #20 o_sclk = 1'b1;
      #20 w = {w[15:0], i_serial_out};
      #140 o_sclk = 1'b0;
    end
    #160 o_cs_n = 1'b1;
    o_serial_in = ~o_serial_in;
  endtask
endmodule // host_model
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking testbench of the converter control block
`include "adc_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import adc_pkg::*;
  localparam int DIV = 2;
  logic clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic ack, sout, sout_en_n, busy, sclk, cs_n, sin;
  logic [16:0] w;
  int n_errors = 0, checks_done = 0, cycles = 0;

  // ************************************************************
  // Design and host
  // ************************************************************
  adc_mode_setup_and_readout #(.CONVERSION_CLOCK_DIV(DIV), .SEG_BITS(3)) u_dut (
    .i_mclk(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_sclk(sclk), .i_cs_n(cs_n), .i_serial_in(sin), .o_serial_out(sout),
    .o_serial_out_en_n(sout_en_n), .o_busy(busy));
  host_model u_host (.i_serial_out(sout), .o_sclk(sclk), .o_cs_n(cs_n), .o_serial_in(sin));

  always #20 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      test_done();
    end
  end

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task test_done;
    if (n_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task check(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task wb(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task xf(input logic [7:0] ins, input int n);
    u_host.xfer(ins, n, w);
    repeat (8) @(posedge clk);
    while (busy !== 1'b0) @(posedge clk);
  endtask

  task wlen(input logic [4:0] e);
    wb(1'b0, `ADDR_STATUS, 32'h0);
    check(32'(q[20:16]), 32'(e));
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task t_defaults;
    wb(1'b0, `ADDR_STATUS, 32'h0);
    check(q & 32'h001f1fff, 32'h000d0c10);
    wb(1'b1, `ADDR_STATUS, 32'hffffffff);
    wb(1'b0, `ADDR_STATUS, 32'h0);
    check(q & 32'h001f1fff, 32'h000d0c10);
    wb(1'b0, 4'h2, 32'h0);
    check(q, 32'h0);
  endtask

  task t_modes;
    logic [7:0] ops [4];
    ops = '{8'h20, 8'h40, 8'h80, 8'h60};
    foreach (ops[i])
    begin
      xf(ops[i], 13);
      wb(1'b0, `ADDR_STATUS, 32'h0);
      check(q & 32'h001f1fe8, 32'h000d0c00);
      check(32'(q[4]), 32'(ops[i] != 8'h80));
    end
    check(32'(q[2:1]), 32'h3);
  endtask

  task t_convert;
    wb(1'b1, `ADDR_SAMPLE, 32'h123);
    xf(8'h00, 13);
    xf(8'h00, 13);
    check(32'(w), 32'h00123);
    wb(1'b0, `ADDR_RESULT, 32'h0);
    check(q, 32'h123);
    wb(1'b1, `ADDR_MEAS, 32'h5);
    xf(8'h40, 13);
    xf(8'h00, 13);
    xf(8'h00, 13);
    check(32'(w), 32'h0011e);
  endtask

  task t_format;
    xf(8'ha0, 13);
    wlen(5'h0c);
    xf(8'h00, 12);
    check(32'(w), 32'h0011e);
    wlen(5'h0c);
    xf(8'h01, 12);
    wlen(5'h10);
    xf(8'ha1, 16);
    check(32'(w), 32'h011e0);
    wlen(5'h11);
    xf(8'h00, 17);
    check(32'(w), 32'h011e0);
    wlen(5'h0d);
  endtask

  task t_settings;
    xf(8'he1, 13);
    xf(8'hc3, 13);
    xf(8'h1e, 13);
    wb(1'b0, `ADDR_STATUS, 32'h0);
    check(32'(q[12:0]), 32'h1efe);
    xf(8'h00, 13);
    check(32'(w), 32'h00f10);
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_defaults();
    t_modes();
    t_convert();
    t_format();
    t_settings();
    test_done();
  end
endmodule // testbench
`default_nettype wire
